// File: lsf_framer.sv
// frame strobe generator and pattern inserter for the sample buses
`timescale 1ns/1ps
// Contract
// - dedicated strobe high only on the last interval (seven at reset frame length)
// - buses C and D clock, strobe may switch off
// - pattern 2 puts strobe on bit zero
// - gate inactive sends full twelve-bit samples
// - gate source selectable, pin after reset
// - pattern 3 sends zeros then all ones
// - dedicated strobe ignores gate; samples still get the pattern while gate active
// - strobe high on last interval of frame
// - frame reference restarts the frame
// - strobe timed with bus data clock
// - per-bus strobe enable bits
module lsf_framer (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    ui_clk_i,
  input  wire logic                    frame_ref_i,
  input  wire logic                    strobe_gate_pin_i,
  input  wire logic                    timestamp_i,
  input  wire logic [3:0][11:0]        sample_i,
  output lsf_pkg::lsf_bus_s [3:0]      bus_o
);
  import lsf_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_last(input logic [7:0] c,
                                   input logic [7:0] len);
    logic [7:0] top;
    top = (len == LSF_ZERO[7:0]) ? LSF_ZERO[7:0] : len - 8'h01;
    return c >= top;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]       flen_reg, flen_next;
  logic [1:0]       pat_reg, pat_next;
  logic [7:0]       lctl_reg, lctl_next;
  logic [7:0]       cse_reg, cse_next;
  logic [31:0]      rdat_reg, rdat_next;
  logic             ack_reg, ack_next;
  logic [2:0]       ui_s_reg, ui_s_next;
  logic [2:0]       fr_s_reg, fr_s_next;
  logic [1:0]       gp_s_reg, gp_s_next;
  logic [1:0]       ts_s_reg, ts_s_next;
  logic [7:0]       cnt_reg, cnt_next;
  logic             last_reg, last_next;
  logic             pend_reg, pend_next;
  lsf_gate_e        gate_reg, gate_next;
  lsf_bus_s [3:0]   bus_reg, bus_next;
  logic             ui_tick;
  logic             fr_rise;
  logic             fr_any;
  logic             gate_src;

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign bus_o    = bus_reg;

  // ----------------------------------------------------------------
  // input synchronisers and edge finding
  // ----------------------------------------------------------------
  always_comb begin
    ui_s_next = {ui_s_reg[1:0], ui_clk_i};
    fr_s_next = {fr_s_reg[1:0], frame_ref_i};
    gp_s_next = {gp_s_reg[0], strobe_gate_pin_i};
    ts_s_next = {ts_s_reg[0], timestamp_i};
  end

  // each link clock edge opens a new unit interval (ddr)
  assign ui_tick = ui_s_reg[2] ^ ui_s_reg[1];
  assign fr_rise = fr_s_reg[1] & ~fr_s_reg[2];
  assign fr_any  = pend_reg | fr_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ui_s_reg <= 3'h0;
      fr_s_reg <= 3'h0;
      gp_s_reg <= 2'h0;
      ts_s_reg <= 2'h0;
    end else begin
      ui_s_reg <= ui_s_next;
      fr_s_reg <= fr_s_next;
      gp_s_reg <= gp_s_next;
      ts_s_reg <= ts_s_next;
    end
  end

  // ----------------------------------------------------------------
  // wishbone register file
  // ----------------------------------------------------------------
  always_comb begin
    flen_next = flen_reg;
    pat_next  = pat_reg;
    lctl_next = lctl_reg;
    cse_next  = cse_reg;
    rdat_next = rdat_reg;
    ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
    if (ack_next) begin
      rdat_next = 32'h0000_0000;
      case (wb_adr_i[7:2])
        LSF_IDX_FLEN: begin
          rdat_next[7:0] = flen_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            flen_next = wb_dat_i[7:0];
          end
        end
        LSF_IDX_PAT: begin
          rdat_next[1:0] = pat_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            pat_next = wb_dat_i[1:0];
          end
        end
        LSF_IDX_LCTL: begin
          rdat_next[7:0] = lctl_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            lctl_next = wb_dat_i[7:0];
          end
        end
        LSF_IDX_CSE: begin
          rdat_next[7:0] = cse_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            cse_next = wb_dat_i[7:0];
          end
        end
        LSF_IDX_STAT: begin
          rdat_next[7:0]       = cnt_reg;
          rdat_next[LSF_ST_GATE] = gate_reg;
        end
        default: begin
          rdat_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flen_reg <= LSF_RST_FLEN;
      pat_reg  <= LSF_RST_PAT;
      lctl_reg <= LSF_RST_LCTL;
      cse_reg  <= LSF_RST_CSE;
      rdat_reg <= 32'h0000_0000;
      ack_reg  <= 1'b0;
    end else begin
      flen_reg <= flen_next;
      pat_reg  <= pat_next;
      lctl_reg <= lctl_next;
      cse_reg  <= cse_next;
      rdat_reg <= rdat_next;
      ack_reg  <= ack_next;
    end
  end

  // ----------------------------------------------------------------
  // gate source select
  // ----------------------------------------------------------------
  always_comb begin
    case (lctl_reg[1:0])
      LSF_SRC_PIN: gate_src = gp_s_reg[1];
      LSF_SRC_SW:  gate_src = lctl_reg[LSF_LC_SYNC];
      LSF_SRC_TS:  gate_src = ts_s_reg[1];
      default:     gate_src = gp_s_reg[1];
    endcase
  end

  // ----------------------------------------------------------------
  // frame counter, gate and bus outputs
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next  = cnt_reg;
    last_next = last_reg;
    pend_next = fr_any;
    gate_next = gate_reg;
    bus_next  = bus_reg;
    if (ui_tick) begin
      pend_next = 1'b0;
      if (fr_any) begin
        cnt_next = 8'h00;
      end else if (last_reg) begin
        cnt_next = 8'h00;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
      last_next = is_last(cnt_next, flen_reg);
      if (cnt_next == 8'h00) begin
        gate_next = gate_src ? LSF_GATE_ON : LSF_GATE_OFF;
      end
      for (int b = 0; b < LSF_NBUS; b++) begin
        // strobe and clock leave with the data of the same interval
        bus_next[b].dclk_en   = cse_reg[LSF_CSE_DCK + b];
        bus_next[b].dclk      = ui_s_reg[1] & cse_reg[LSF_CSE_DCK + b];
        bus_next[b].strobe_en = cse_reg[b];
        bus_next[b].strobe    = last_next & cse_reg[b];
        bus_next[b].data      = sample_i[b];
        if (gate_next == LSF_GATE_ON) begin
          case (pat_reg)
            LSF_PAT_LSB: begin
              bus_next[b].data[0] = last_next;
            end
            LSF_PAT_ALL: begin
              bus_next[b].data = last_next ? LSF_ONES : LSF_ZERO;
            end
            default: begin
              bus_next[b].data = sample_i[b];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= 8'h00;
      last_reg <= 1'b0;
      pend_reg <= 1'b0;
      gate_reg <= LSF_GATE_OFF;
      bus_reg  <= '0;
    end else begin
      cnt_reg  <= cnt_next;
      last_reg <= last_next;
      pend_reg <= pend_next;
      gate_reg <= gate_next;
      bus_reg  <= bus_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tick_gated(logic [1:0] p);
    ui_tick && pat_reg == p ##1 gate_reg == LSF_GATE_ON;
  endsequence

  a_strobe_on_last: assert property (
    $rose(bus_o[0].strobe) |-> last_reg && cnt_reg != 8'h00
      || flen_reg <= 8'h01)
    else $error("strobe rose outside last interval");

  a_counter_wrap: assert property (
    ui_tick && last_reg && !fr_any |=> cnt_reg == 8'h00)
    else $error("counter did not wrap after last interval");

  a_fref_restart: assert property (
    ui_tick && fr_any |=> cnt_reg == 8'h00 && !pend_reg)
    else $error("frame reference did not restart frame");

  a_lsb_strobe: assert property (
    s_tick_gated(LSF_PAT_LSB) |-> bus_o[1].data[0] == last_reg
      && bus_o[1].data[11:1] == $past(sample_i[1][11:1]))
    else $error("lsb replacement wrong");

  a_full_pattern: assert property (
    s_tick_gated(LSF_PAT_ALL)
      |-> bus_o[2].data == (last_reg ? LSF_ONES : LSF_ZERO))
    else $error("whole sample pattern wrong");

  a_raw_sample: assert property (
    ui_tick && gate_next == LSF_GATE_OFF
      |=> bus_o[3].data == $past(sample_i[3]))
    else $error("sample not passed whole while gate off");

  a_gate_boundary: assert property (
    $changed(gate_reg) |-> cnt_reg == 8'h00)
    else $error("gate changed inside a frame");

  a_strobe_disable: assert property (
    ui_tick && !cse_reg[0] |=> !bus_o[0].strobe && !bus_o[0].strobe_en)
    else $error("disabled strobe still driven");

  a_strobe_any_gate: assert property (
    ui_tick |=> bus_o[1].strobe == (last_reg && $past(cse_reg[1])))
    else $error("dedicated strobe not on last interval");

  a_dclk_off: assert property (
    ui_tick && !cse_reg[LSF_CSE_DCK + 2]
      |=> !bus_o[2].dclk && !bus_o[2].dclk_en)
    else $error("disabled data clock still driven");

  a_gate_from_pin: assert property (
    ui_tick && cnt_next == 8'h00 && lctl_reg[1:0] == LSF_SRC_PIN
      |=> (gate_reg == LSF_GATE_ON) == $past(gp_s_reg[1]))
    else $error("gate not taken from pin source");

  a_wb_ack_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle pulse");
endmodule

// File: lsf_framer_test.sv
// self-checking testbench for the strobe framing block
`timescale 1ns/1ps
module lsf_framer_test;
  import lsf_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc   = 1'b0;
  logic             stb   = 1'b0;
  logic             we    = 1'b0;
  logic [3:0]       sel   = 4'h0;
  logic [7:0]       adr   = 8'h00;
  logic [31:0]      dat   = 32'h0;
  logic             ui    = 1'b0;
  logic             fref  = 1'b0;
  logic             gpin  = 1'b0;
  logic             ts    = 1'b0;
  logic [3:0][11:0] smp   = '0;
  logic [2:0]       uc    = 3'h0;
  logic [7:0]       n     = 8'h00;
  logic [31:0]      dat_o;
  logic             ack_o;
  lsf_bus_s [3:0]   bus_o;
  logic [11:0]      last_c;
  logic [11:0]      last_d;
  int               fails = 0;
  int               comparisons = 0;
  event             ui_ev;

  always #2 clk_i = ~clk_i;

  function automatic logic [11:0] sv(input int b, input logic [7:0] k);
    return {b[3:0], k};
  endfunction

  // link clock of 64 ns, one new sample per unit interval
  always @(posedge clk_i) begin
    uc <= uc + 3'h1;
    if (uc == 3'h7) begin
      ui <= ~ui;
      n <= n + 8'h01;
      for (int b = 0; b < 4; b++) smp[b] <= sv(b, n + 8'h01);
      -> ui_ev;
    end
  end

  lsf_framer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(dat_o), .wb_ack_o(ack_o), .ui_clk_i(ui),
    .frame_ref_i(fref), .strobe_gate_pin_i(gpin), .timestamp_i(ts),
    .sample_i(smp), .bus_o(bus_o)
  );

  lsf_rx_model i_rx (.clk_i(clk_i), .bus_i(bus_o), .last_c_o(last_c),
                     .last_d_o(last_d));

  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'hF;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    we <= 1'b0;
  endtask

  task setp(input logic [7:0] a, input logic [31:0] d, input logic gp,
            input logic t);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    @(posedge clk_i);
    gpin <= gp;
    ts <= t;
  endtask

  task at_ui;
    @(ui_ev);
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // restart the frame, then judge every bus on each unit interval
  task frame(input int fl, input logic [1:0] p, input logic g,
             input logic [7:0] cse, input logic flip);
    logic [11:0] s;
    logic [11:0] e;
    logic        l;
    @(ui_ev);
    @(posedge clk_i);
    fref <= 1'b1;
    repeat (6) @(posedge clk_i);
    fref <= 1'b0;
    for (int i = 0; i < fl; i++) begin
      at_ui;
      l = (i == fl - 1);
      for (int b = 0; b < 4; b++) begin
        s = sv(b, n);
        e = (g && p == LSF_PAT_LSB) ? {s[11:1], l} :
            (g && p == LSF_PAT_ALL) ? (l ? LSF_ONES : LSF_ZERO) : s;
        chk(32'(bus_o[b].data), 32'(e));
        chk(32'(bus_o[b].strobe), 32'(l & cse[b]));
        chk(32'({bus_o[b].strobe_en, bus_o[b].dclk_en}),
            32'({cse[b], cse[4+b]}));
        if (!cse[4+b]) chk(32'(bus_o[b].dclk), 32'h0);
        else chk(32'(bus_o[b].dclk), 32'(ui));
      end
      if (flip && i == 3) begin
        @(posedge clk_i);
        gpin <= ~gpin;
      end
    end
  endtask

  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    results;
  end

  initial begin
    logic [31:0] q;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, LSF_ADR_FLEN, 32'h0, q);
    chk(q, 32'h08);
    wb(1'b0, LSF_ADR_LCTL, 32'h0, q);
    chk(q, 32'h00);
    wb(1'b0, LSF_ADR_CSE, 32'h0, q);
    chk(q, 32'hFF);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    frame(8, LSF_PAT_NORM, 1'b0, 8'hFF, 1'b0);
    setp(LSF_ADR_PAT, 32'h2, 1'b1, 1'b0);
    frame(8, LSF_PAT_LSB, 1'b1, 8'hFF, 1'b0);
    setp(LSF_ADR_PAT, 32'h2, 1'b0, 1'b0);
    frame(8, LSF_PAT_LSB, 1'b0, 8'hFF, 1'b0);
    setp(LSF_ADR_PAT, 32'h3, 1'b1, 1'b0);
    wb(1'b0, LSF_ADR_PAT, 32'h0, q);
    chk(q, 32'h3);
    frame(8, LSF_PAT_ALL, 1'b1, 8'hFF, 1'b1);
    wb(1'b0, LSF_ADR_STAT, 32'h0, q);
    chk(q, 32'h0000_0107);
    frame(8, LSF_PAT_ALL, 1'b0, 8'hFF, 1'b0);
    setp(LSF_ADR_LCTL, 32'h11, 1'b0, 1'b0);
    frame(8, LSF_PAT_ALL, 1'b1, 8'hFF, 1'b0);
    setp(LSF_ADR_LCTL, 32'h02, 1'b1, 1'b1);
    frame(8, LSF_PAT_ALL, 1'b1, 8'hFF, 1'b0);
    setp(LSF_ADR_LCTL, 32'h02, 1'b1, 1'b0);
    frame(8, LSF_PAT_ALL, 1'b0, 8'hFF, 1'b0);
    setp(LSF_ADR_LCTL, 32'h00, 1'b0, 1'b0);
    setp(LSF_ADR_FLEN, 32'h05, 1'b0, 1'b0);
    setp(LSF_ADR_CSE, 32'h33, 1'b0, 1'b0);
    frame(5, LSF_PAT_ALL, 1'b0, 8'h33, 1'b0);
    chk(32'(last_c), 32'(sv(2, n)));
    chk(32'(last_d), 32'(sv(3, n)));
    results;
  end
endmodule

// File: lsf_pkg.sv
// constants and carrier types for the strobe framing block
package lsf_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned LSF_NBUS = 4;
  localparam int unsigned LSF_SW   = 12;
  localparam int unsigned LSF_FW   = 8;
  // ----------------------------------------------------------------
  // register byte offsets and word indices
  // ----------------------------------------------------------------
  localparam logic [7:0] LSF_ADR_FLEN = 8'h00;
  localparam logic [7:0] LSF_ADR_PAT  = 8'h04;
  localparam logic [7:0] LSF_ADR_LCTL = 8'h08;
  localparam logic [7:0] LSF_ADR_CSE  = 8'h0C;
  localparam logic [7:0] LSF_ADR_STAT = 8'h10;
  localparam logic [5:0] LSF_IDX_FLEN = LSF_ADR_FLEN[7:2];
  localparam logic [5:0] LSF_IDX_PAT  = LSF_ADR_PAT[7:2];
  localparam logic [5:0] LSF_IDX_LCTL = LSF_ADR_LCTL[7:2];
  localparam logic [5:0] LSF_IDX_CSE  = LSF_ADR_CSE[7:2];
  localparam logic [5:0] LSF_IDX_STAT = LSF_ADR_STAT[7:2];
  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] LSF_RST_FLEN = 8'h08;
  localparam logic [1:0] LSF_RST_PAT  = 2'h0;
  localparam logic [7:0] LSF_RST_LCTL = 8'h00;
  localparam logic [7:0] LSF_RST_CSE  = 8'hFF;
  localparam int unsigned LSF_LC_SYNC = 4;
  localparam int unsigned LSF_CSE_DCK = 4;
  localparam int unsigned LSF_ST_GATE = 8;
  // ----------------------------------------------------------------
  // pattern and gate source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LSF_PAT_NORM = 2'h0;
  localparam logic [1:0] LSF_PAT_LSB  = 2'h2;
  localparam logic [1:0] LSF_PAT_ALL  = 2'h3;
  localparam logic [1:0] LSF_SRC_PIN  = 2'h0;
  localparam logic [1:0] LSF_SRC_SW   = 2'h1;
  localparam logic [1:0] LSF_SRC_TS   = 2'h2;
  localparam logic [11:0] LSF_ONES    = 12'hFFF;
  localparam logic [11:0] LSF_ZERO    = 12'h000;

  typedef enum logic {
    LSF_GATE_OFF = 1'b0,
    LSF_GATE_ON  = 1'b1
  } lsf_gate_e;

  typedef struct packed {
    logic [11:0] data;
    logic        strobe;
    logic        strobe_en;
    logic        dclk;
    logic        dclk_en;
  } lsf_bus_s;
endpackage

// File: lsf_rx_model.sv
// receiver model capturing buses C and D with the clock, strobe of A, B
`timescale 1ns/1ps
module lsf_rx_model (
  input  wire logic                    clk_i,
  input  wire lsf_pkg::lsf_bus_s [3:0] bus_i,
  output logic [11:0]                  last_c_o,
  output logic [11:0]                  last_d_o
);
  import lsf_pkg::*;
  logic a_clk_reg = 1'b0;
  logic b_clk_reg = 1'b0;
  // a data clock edge with its strobe high marks the last interval
  always @(posedge clk_i) begin
    a_clk_reg <= bus_i[0].dclk;
    b_clk_reg <= bus_i[1].dclk;
    if (bus_i[0].dclk != a_clk_reg && bus_i[0].strobe) begin
      last_c_o <= bus_i[2].data;
    end
    if (bus_i[1].dclk != b_clk_reg && bus_i[1].strobe) begin
      last_d_o <= bus_i[3].data;
    end
  end
endmodule
